// file: hw/rx_sync_packet_fifo_level.v
// receive channel: sync acquisition, packet counting and fifo level ports
//
// Behaviour
// - divide reference for 8x receive sample clock
// - resync bit discards alignment, searches pattern again
// - resync self-clears on match; first acquisition automatic
// - packet longword count register, read-write 32 bits
// - wait sync, count longwords, flag complete, research (handshaked channels only; downlink keeps capturing)
// - same register holds four selectable sync bytes
// - compare all 32 bits, unselected bytes ignored
// - static first bit from pattern MSB mux
// - free-wheel decoder slips phase on 00/11
// - state-machine fifo count in low 16 bits
// - summed fifo counts above level raise status
// - without extra fifos sum dma plus pipeline
// - external fifo count resynchronised, read-only
// - transmit path total count, read-only
// - transmit total while receiving returns shared part
// - receive total; while transmitting shared part
`timescale 1ns/1ps
`default_nettype none
`include "rx_sync_defs.vh"
module rx_sync_packet_fifo_level #(
  parameter DIV_W          = 12,
  parameter CNT_W          = 16,
  parameter HAS_EXT_FIFOS  = 0
) (
  // clock and reset
  input  wire              ref_clk,
  input  wire              resetn,
  input  wire              ce,
  // register port
  input  wire [7:0]        regAddr,
  input  wire              regWrite,
  input  wire              regRead,
  input  wire [31:0]       regWrData,
  output reg  [31:0]       regRdData,
  // channel control
  input  wire              rxEnable,
  input  wire              isDownlink,
  input  wire              txActive,
  input  wire              syncReacquireSet,
  input  wire [3:0]        syncByteSelect,
  input  wire              staticOrFreewheelSelect,
  input  wire              levelInterruptEnable,
  input  wire [DIV_W-1:0]  downlinkDivisor,
  // line inputs
  input  wire              downlinkLine,
  input  wire              hsStart,
  input  wire              hsBitValid,
  input  wire              hsBit,
  // fifo counts
  input  wire [CNT_W-1:0]  rxDmaCount,
  input  wire [CNT_W-1:0]  pipelineCount,
  input  wire [CNT_W-1:0]  extFifoCount,
  input  wire [CNT_W-1:0]  smFifoCount,
  input  wire [CNT_W-1:0]  txDmaCount,
  input  wire [CNT_W-1:0]  txSmCount,
  // status and data out
  output reg               syncReacquireRequest,
  output reg               syncFound,
  output reg               packetComplete,
  output reg               capturing,
  output reg               levelStatus,
  output reg               levelInterrupt,
  output reg               rxWordValid,
  output reg  [31:0]       rxWord
);
  localparam ST_IDLE    = 2'h0;
  localparam ST_SEARCH  = 2'h1;
  localparam ST_CAPTURE = 2'h2;

  // byte mask of the selected sync bytes
  function [31:0] syncMask;
    input [3:0] sel;
    begin
      syncMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // msb of the most significant selected byte, or bit 31 when none
  function expectFirst;
    input [3:0]  sel;
    input [31:0] pat;
    begin
      if (sel[3] || (sel == 4'h0))
        expectFirst = pat[`PAT_B3_MSB];
      else if (sel[2])
        expectFirst = pat[`PAT_B2_MSB];
      else if (sel[1])
        expectFirst = pat[`PAT_B1_MSB];
      else
        expectFirst = pat[`PAT_B0_MSB];
    end
  endfunction

  // zero-extend a count to 32 bits
  function [31:0] ext32;
    input [CNT_W-1:0] c;
    begin
      ext32 = {{(32-CNT_W){1'b0}}, c};
    end
  endfunction

  reg [31:0]      patternLen_reg;
  reg [31:0]      afLevel_reg;
  reg [1:0]       state_reg;
  reg [1:0]       state_next;
  reg [31:0]      syncShift_reg;
  reg [31:0]      wordShift_reg;
  reg [4:0]       bitCnt_reg;
  reg [31:0]      wordCnt_reg;
  reg             enable_reg;
  reg             restart_reg;
  reg [CNT_W-1:0] extMeta_reg;
  reg [CNT_W-1:0] extSync_reg;
  reg [CNT_W-1:0] smMeta_reg;
  reg [CNT_W-1:0] smSync_reg;
  reg [31:0]      levelSum;
  reg [31:0]      txTotal;
  reg [31:0]      rxTotal;
  reg [31:0]      rdMux;

  wire        sampleTick;
  wire        dlBitValid;
  wire        dlBitValue;
  wire        bitValid;
  wire        bitValue;
  wire [31:0] syncShiftNext;
  wire        patternHit;
  wire        firstBitExp;

  rx_rate_divider #(
    .DIV_W (DIV_W)
  ) u_div (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .ce         (ce),
    .divisor    (downlinkDivisor),
    .sampleTick (sampleTick)
  );

  assign firstBitExp = expectFirst(syncByteSelect, patternLen_reg);

  manchester_phase_align u_align (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .ce         (ce),
    .sampleTick (sampleTick),
    .restart    (restart_reg),
    .staticMode (staticOrFreewheelSelect),
    .firstBit   (firstBitExp),
    .lineIn     (downlinkLine),
    .bitValid   (dlBitValid),
    .bitValue   (dlBitValue)
  );

  // handshaked channels deliver bits on their own received clock strobe
  assign bitValid      = isDownlink ? dlBitValid : hsBitValid;
  assign bitValue      = isDownlink ? dlBitValue : hsBit;
  assign syncShiftNext = {syncShift_reg[30:0], bitValue};
  // all 32 bits compared, deselected bytes masked to don't-care
  assign patternHit    = ((syncShiftNext ^ patternLen_reg) & syncMask(syncByteSelect)) == `RST_WORD;

  // register writes
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      patternLen_reg <= `RST_WORD;
      afLevel_reg    <= `RST_WORD;
    end else if (ce && regWrite) begin
      if (regAddr == `ADDR_PATTERN_LEN)
        patternLen_reg <= regWrData;
      if (regAddr == `ADDR_AF_LEVEL)
        afLevel_reg <= regWrData;
    end
  end

  // receive sequencing
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (enable_reg)
          state_next = ST_SEARCH;
      end
      ST_SEARCH: begin
        if (isDownlink ? (bitValid && patternHit) : hsStart)
          state_next = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        // only handshaked channels know where a packet ends
        if (!isDownlink && bitValid && (bitCnt_reg == `BIT_LAST)
            && (wordCnt_reg + 32'h0000_0001 >= patternLen_reg))
          state_next = ST_SEARCH;
      end
      default: state_next = ST_IDLE;
    endcase
    if (!enable_reg)
      state_next = ST_IDLE;
    else if (syncReacquireSet)
      state_next = ST_SEARCH;
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg            <= ST_IDLE;
      enable_reg           <= 1'b0;
      restart_reg          <= 1'b0;
      syncShift_reg        <= `RST_WORD;
      wordShift_reg        <= `RST_WORD;
      bitCnt_reg           <= `BIT_FIRST;
      wordCnt_reg          <= `RST_WORD;
      syncReacquireRequest <= 1'b0;
      syncFound            <= 1'b0;
      packetComplete       <= 1'b0;
      capturing            <= 1'b0;
      rxWordValid          <= 1'b0;
      rxWord               <= `RST_WORD;
    end else if (ce) begin
      enable_reg     <= rxEnable;
      state_reg      <= state_next;
      packetComplete <= 1'b0;
      syncFound      <= 1'b0;
      rxWordValid    <= 1'b0;
      capturing      <= (state_next == ST_CAPTURE);
      // a fresh enable or a resync throws away the current alignment
      restart_reg    <= syncReacquireSet || (rxEnable && !enable_reg);
      if (syncReacquireSet || (state_reg == ST_IDLE)) begin
        syncShift_reg <= `RST_WORD;
        bitCnt_reg    <= `BIT_FIRST;
        wordCnt_reg   <= `RST_WORD;
      end else if (state_reg == ST_SEARCH) begin
        if (bitValid)
          syncShift_reg <= syncShiftNext;
        if (state_next == ST_CAPTURE) begin
          syncFound     <= 1'b1;
          wordShift_reg <= `RST_WORD;
          bitCnt_reg    <= `BIT_FIRST;
          wordCnt_reg   <= `RST_WORD;
        end
      end else if ((state_reg == ST_CAPTURE) && bitValid) begin
        // downlink stays here until stopped or resynced; idle is not detectable
        wordShift_reg <= {wordShift_reg[30:0], bitValue};
        bitCnt_reg    <= bitCnt_reg + 5'h01;
        if (bitCnt_reg == `BIT_LAST) begin
          rxWordValid <= 1'b1;
          rxWord      <= {wordShift_reg[30:0], bitValue};
          wordCnt_reg <= wordCnt_reg + 32'h0000_0001;
          if (state_next == ST_SEARCH) begin
            packetComplete <= 1'b1;
            syncShift_reg  <= `RST_WORD;
          end
        end
      end
      // a new request wins over the clear by a match in the same cycle
      if (syncReacquireSet)
        syncReacquireRequest <= 1'b1;
      else if ((state_reg == ST_SEARCH) && (state_next == ST_CAPTURE))
        syncReacquireRequest <= 1'b0;
    end
  end

  // fifo counts from the foreign clock: per-bit double flop, may jump while moving
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      extMeta_reg <= {CNT_W{1'b0}};
      extSync_reg <= {CNT_W{1'b0}};
      smMeta_reg  <= {CNT_W{1'b0}};
      smSync_reg  <= {CNT_W{1'b0}};
    end else if (ce) begin
      extMeta_reg <= extFifoCount;
      extSync_reg <= extMeta_reg;
      smMeta_reg  <= smFifoCount;
      smSync_reg  <= smMeta_reg;
    end
  end

  always @* begin
    if (HAS_EXT_FIFOS != 0)
      levelSum = ext32(rxDmaCount) + ext32(extSync_reg) + ext32(smSync_reg);
    else
      levelSum = ext32(rxDmaCount) + ext32(pipelineCount);
    // the external fifo is shared: the other direction sees only that part
    if (rxEnable)
      txTotal = ext32(extSync_reg);
    else
      txTotal = ext32(txDmaCount) + ext32(extSync_reg) + ext32(txSmCount);
    if (txActive)
      rxTotal = ext32(extSync_reg);
    else
      rxTotal = ext32(rxDmaCount) + ext32(extSync_reg) + ext32(smSync_reg);
  end

  always @* begin
    case (regAddr)
      `ADDR_PATTERN_LEN: rdMux = patternLen_reg;
      `ADDR_SM_LEVEL:    rdMux = {16'h0000, smSync_reg[15:0]};
      `ADDR_AF_LEVEL:    rdMux = afLevel_reg;
      `ADDR_EXT_LEVEL:   rdMux = ext32(extSync_reg);
      `ADDR_TX_TOTAL:    rdMux = txTotal;
      `ADDR_RX_TOTAL:    rdMux = rxTotal;
      default:           rdMux = `RST_WORD;
    endcase
  end

  // level status holds while the sum exceeds the level
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData      <= `RST_WORD;
      levelStatus    <= 1'b0;
      levelInterrupt <= 1'b0;
    end else if (ce) begin
      if (regRead)
        regRdData <= rdMux;
      levelStatus    <= (levelSum > afLevel_reg);
      levelInterrupt <= (levelSum > afLevel_reg) && levelInterruptEnable;
    end
  end
endmodule // rx_sync_packet_fifo_level
`default_nettype wire

// file: hw/rx_sync_defs.vh
// register offsets, field positions and constants for the receive channel
`ifndef RX_SYNC_DEFS_VH
`define RX_SYNC_DEFS_VH

// register byte offsets
`define ADDR_PATTERN_LEN   8'h38
`define ADDR_SM_LEVEL      8'h3C
`define ADDR_AF_LEVEL      8'h40
`define ADDR_EXT_LEVEL     8'h44
`define ADDR_TX_TOTAL      8'h48
`define ADDR_RX_TOTAL      8'h4C

// reset values
`define RST_WORD           32'h0000_0000
`define RST_DIVISOR        12'h004

// sync pattern byte MSB positions
`define PAT_B3_MSB         31
`define PAT_B2_MSB         23
`define PAT_B1_MSB         15
`define PAT_B0_MSB         7

// oversampling phase counter (8 samples per bit)
`define PH_START           3'h0
`define PH_AFTER_EDGE      3'h1
`define PH_MID_EDGE        3'h5
`define PH_FIRST_SAMPLE    3'h2
`define PH_SECOND_SAMPLE   3'h6
`define PH_SLIP            3'h3

// bit counter within a longword
`define BIT_LAST           5'h1F
`define BIT_FIRST          5'h00

`endif

// file: hw/rx_rate_divider.v
// divides the reference clock into the eight-times oversampling strobe
`timescale 1ns/1ps
`default_nettype none
module rx_rate_divider #(
  parameter DIV_W = 12
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             resetn,
  input  wire             ce,
  // control
  input  wire [DIV_W-1:0] divisor,
  // strobe out
  output reg              sampleTick
);
  reg [DIV_W-1:0] count_reg;
  reg             square_reg;

  // square wave toggles every divisor counts; its rising edge is the sample strobe
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg  <= {DIV_W{1'b0}};
      square_reg <= 1'b0;
      sampleTick <= 1'b0;
    end else if (ce) begin
      sampleTick <= 1'b0;
      if (count_reg + {{(DIV_W-1){1'b0}}, 1'b1} >= divisor) begin
        count_reg  <= {DIV_W{1'b0}};
        square_reg <= ~square_reg;
        sampleTick <= ~square_reg;
      end else begin
        count_reg <= count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // rx_rate_divider
`default_nettype wire

// file: hw/manchester_phase_align.v
// manchester half-bit phase alignment and bit recovery
`timescale 1ns/1ps
`default_nettype none
`include "rx_sync_defs.vh"
module manchester_phase_align (
  // clock and reset
  input  wire ref_clk,
  input  wire resetn,
  input  wire ce,
  // control
  input  wire sampleTick,
  input  wire restart,
  input  wire staticMode,
  input  wire firstBit,
  // line
  input  wire lineIn,
  // recovered bits
  output reg  bitValid,
  output reg  bitValue
);
  reg [2:0] phase_reg;
  reg       started_reg;
  reg       lastLine_reg;
  reg       firstHalf_reg;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg     <= `PH_START;
      started_reg   <= 1'b0;
      lastLine_reg  <= 1'b0;
      firstHalf_reg <= 1'b0;
      bitValid      <= 1'b0;
      bitValue      <= 1'b0;
    end else if (ce) begin
      bitValid <= 1'b0;
      if (restart) begin
        started_reg <= 1'b0;
        phase_reg   <= `PH_START;
      end else if (sampleTick) begin
        lastLine_reg <= lineIn;
        if (!started_reg) begin
          // start on the first edge; in static mode the idle level tells whether it is mid-bit
          if (lineIn != lastLine_reg) begin
            started_reg   <= 1'b1;
            firstHalf_reg <= lastLine_reg;
            if (staticMode && (lastLine_reg == firstBit))
              phase_reg <= `PH_MID_EDGE;
            else
              phase_reg <= `PH_AFTER_EDGE;
          end
        end else begin
          phase_reg <= phase_reg + 3'h1;
          if (phase_reg == `PH_FIRST_SAMPLE)
            firstHalf_reg <= lineIn;
          if (phase_reg == `PH_SECOND_SAMPLE) begin
            if (!staticMode && (firstHalf_reg == lineIn)) begin
              // 00 or 11 is illegal: this sample becomes a first half
              firstHalf_reg <= lineIn;
              phase_reg     <= `PH_SLIP;
            end else begin
              bitValid <= 1'b1;
              bitValue <= firstHalf_reg;
            end
          end
        end
      end
    end
  end
endmodule // manchester_phase_align
`default_nettype wire

// file: testbench/rx_sync_packet_fifo_level_assertions.sv
// concurrent checks on the receive channel ports
`timescale 1ns/1ps
`default_nettype none
module rx_sync_packet_fifo_level_assertions #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             resetn,
  // register port
  input wire logic [7:0]       regAddr,
  input wire logic             regWrite,
  input wire logic             regRead,
  input wire logic [31:0]      regWrData,
  input wire logic [31:0]      regRdData,
  // control
  input wire logic             rxEnable,
  input wire logic             txActive,
  input wire logic             syncReacquireSet,
  input wire logic             levelInterruptEnable,
  // counts
  input wire logic [CNT_W-1:0] rxDmaCount,
  input wire logic [CNT_W-1:0] pipelineCount,
  input wire logic [CNT_W-1:0] extFifoCount,
  input wire logic [CNT_W-1:0] smFifoCount,
  // status
  input wire logic             syncReacquireRequest,
  input wire logic             syncFound,
  input wire logic             packetComplete,
  input wire logic             capturing,
  input wire logic             levelStatus,
  input wire logic             levelInterrupt
);
  logic [31:0] aflShadow;
  logic [32:0] sumNow;
  logic        gt;
  // shadow of the almost-full level so the comparison is judged independently
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) aflShadow <= 32'h0000_0000;
    else if (regWrite && regAddr == 8'h40) aflShadow <= regWrData;
  end
  assign sumNow = rxDmaCount + pipelineCount;
  assign gt     = sumNow > {1'b0, aflShadow};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence rdAt(a);
    regRead && regAddr == a;
  endsequence
  // counts cross a two-flop sync, so only settled values are judged
  sequence steady(x);
    $stable(x) [*3];
  endsequence
  AST_RESYNC_SET: assert property (syncReacquireSet |=> syncReacquireRequest)
    else $error("resync request not raised");
  AST_RESYNC_CLEAR: assert property ($rose(syncFound) && !syncReacquireSet |-> ##[0:1] !syncReacquireRequest)
    else $error("resync request not cleared on match");
  AST_FOUND_CAPTURE: assert property (syncFound |-> ##[0:1] capturing)
    else $error("no capture after sync");
  AST_PKT_SEARCH: assert property (packetComplete |-> ##[0:1] !capturing)
    else $error("capture continues after packet end");
  AST_LEVEL_STATUS: assert property (steady(gt) |-> levelStatus == gt)
    else $error("level status wrong");
  AST_LEVEL_IRQ_ON: assert property ((levelStatus && levelInterruptEnable) [*2] |-> levelInterrupt)
    else $error("level interrupt missing");
  AST_LEVEL_IRQ_OFF: assert property (!levelInterruptEnable |=> !levelInterrupt)
    else $error("level interrupt not masked");
  AST_SM_LEVEL: assert property (steady(smFifoCount) ##0 rdAt(8'h3C) |-> ##1 regRdData == 32'(smFifoCount))
    else $error("state machine level read wrong");
  AST_EXT_LEVEL: assert property (steady(extFifoCount) ##0 rdAt(8'h44) |-> ##1 regRdData == 32'(extFifoCount))
    else $error("external level read wrong");
  AST_TX_TOTAL: assert property (steady(extFifoCount) ##0 rdAt(8'h48) ##0 rxEnable |-> ##1 regRdData == 32'(extFifoCount))
    else $error("tx total while receiving wrong");
  AST_RX_TOTAL: assert property (steady(extFifoCount) ##0 rdAt(8'h4C) ##0 txActive |-> ##1 regRdData == 32'(extFifoCount))
    else $error("rx total while transmitting wrong");
endmodule // rx_sync_packet_fifo_level_assertions
bind rx_sync_packet_fifo_level rx_sync_packet_fifo_level_assertions #(.CNT_W(CNT_W)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regWrData(regWrData), .regRdData(regRdData), .rxEnable(rxEnable), .txActive(txActive),
  .syncReacquireSet(syncReacquireSet), .levelInterruptEnable(levelInterruptEnable), .rxDmaCount(rxDmaCount),
  .pipelineCount(pipelineCount), .extFifoCount(extFifoCount), .smFifoCount(smFifoCount),
  .syncReacquireRequest(syncReacquireRequest), .syncFound(syncFound), .packetComplete(packetComplete),
  .capturing(capturing), .levelStatus(levelStatus), .levelInterrupt(levelInterrupt));
`default_nettype wire

// file: testbench/manchester_line_model.sv
// manchester downlink sender: queued bits, idle fill between frames
`timescale 1ns/1ps
`default_nettype none
module manchester_line_model #(
  parameter int BIT_CYC = 64
) (
  // clock and mode
  input  wire logic ref_clk,
  input  wire logic staticMode,
  // line
  output var  logic lineOut
);
  logic q[$];
  logic idleBit;
  logic h1, h2;
  task automatic sendWord(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) q.push_back(w[i]);
  endtask
  // one bit lasts exactly the programmed rate, well inside the tolerated band
  initial begin
    lineOut = 1'b0;
    idleBit = 1'b0;
    @(posedge ref_clk);
    #1;
    forever begin
      if (q.size() > 0) begin
        h1 = q.pop_front();
        h2 = ~h1;
      end else if (staticMode) begin
        h1 = 1'b0;
        h2 = 1'b0;
      end else begin
        h1 = idleBit;
        h2 = ~idleBit;
        idleBit = ~idleBit;
      end
      lineOut = h1;
      repeat (BIT_CYC / 2) @(posedge ref_clk);
      #1 lineOut = h2;
      repeat (BIT_CYC / 2) @(posedge ref_clk);
      #1;
    end
  end
endmodule // manchester_line_model
`default_nettype wire

// file: testbench/test_rx_sync_packet_fifo_level.sv
// self-checking bench for the receive channel block
`timescale 1ns/1ps
`default_nettype none
module test_rx_sync_packet_fifo_level;
  logic        ref_clk, resetn, regWrite, regRead, rxEnable, isDownlink, txActive, syncReacquireSet;
  logic        staticOrFreewheelSelect, levelInterruptEnable, hsStart, hsBitValid, hsBit;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, rdVal, lastWord;
  logic [3:0]  syncByteSelect;
  logic [15:0] rxDmaCount, pipelineCount, extFifoCount, smFifoCount, txDmaCount, txSmCount;
  wire  [31:0] regRdData, rxWord;
  wire         downlinkLine, syncReacquireRequest, syncFound, packetComplete, capturing;
  wire         levelStatus, levelInterrupt, rxWordValid;
  int          error_cnt = 0, n_tests = 0, wordCnt = 0, foundCnt = 0, pcCnt = 0, base;

  rx_sync_packet_fifo_level u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWrData(regWrData), .regRdData(regRdData), .rxEnable(rxEnable), .isDownlink(isDownlink),
    .txActive(txActive), .syncReacquireSet(syncReacquireSet), .syncByteSelect(syncByteSelect),
    .staticOrFreewheelSelect(staticOrFreewheelSelect), .levelInterruptEnable(levelInterruptEnable),
    .downlinkDivisor(12'h004), .downlinkLine(downlinkLine), .hsStart(hsStart), .hsBitValid(hsBitValid),
    .hsBit(hsBit), .rxDmaCount(rxDmaCount), .pipelineCount(pipelineCount), .extFifoCount(extFifoCount),
    .smFifoCount(smFifoCount), .txDmaCount(txDmaCount), .txSmCount(txSmCount),
    .syncReacquireRequest(syncReacquireRequest), .syncFound(syncFound), .packetComplete(packetComplete),
    .capturing(capturing), .levelStatus(levelStatus), .levelInterrupt(levelInterrupt),
    .rxWordValid(rxWordValid), .rxWord(rxWord));
  // divisor 4: tick every 8 cycles, 8 ticks a bit
  manchester_line_model #(.BIT_CYC(64)) u_line (
    .ref_clk(ref_clk), .staticMode(staticOrFreewheelSelect), .lineOut(downlinkLine));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // one-cycle pulses are caught here so no task can miss them
  always @(posedge ref_clk) begin
    if (rxWordValid === 1'b1) begin
      lastWord <= rxWord;
      wordCnt <= wordCnt + 1;
    end
    if (syncFound === 1'b1) foundCnt <= foundCnt + 1;
    if (packetComplete === 1'b1) pcCnt <= pcCnt + 1;
  end

  task automatic conclude();
    $display("compares %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    tick(1);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr = a;
    regRead = 1'b1;
    tick(1);
    regRead = 1'b0;
    tick(1);
    rdVal = regRdData;
  endtask
  task automatic waitCnt(ref int c, input int tgt);
    for (int i = 0; i < 6000; i++) begin
      if (c >= tgt) return;
      tick(1);
    end
    check(c, tgt);
    conclude();
  endtask
  task automatic hsWord(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      hsBit = w[i];
      hsBitValid = 1'b1;
      tick(1);
      hsBitValid = 1'b0;
      tick(1);
    end
  endtask

  initial begin
    {regWrite, regRead, rxEnable, isDownlink, txActive, syncReacquireSet, hsStart, hsBitValid, hsBit} = '0;
    {staticOrFreewheelSelect, levelInterruptEnable} = '0;
    regAddr = 8'h00;
    regWrData = 32'h0000_0000;
    syncByteSelect = 4'h0;
    {rxDmaCount, pipelineCount, txDmaCount, txSmCount} = '0;
    smFifoCount = 16'h0123;
    extFifoCount = 16'h0456;
    resetn = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 resetn = 1'b1;
    tick(1);
    rd(8'h38); check(rdVal, 32'h0000_0000);
    rd(8'h40); check(rdVal, 32'h0000_0000);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C); check(rdVal, 32'h0000_0123);
    rd(8'h44); check(rdVal, 32'h0000_0456);
    rd(8'h50); check(rdVal, 32'h0000_0000);
    txActive = 1'b1;
    rd(8'h4C); check(rdVal, 32'h0000_0456);
    txActive = 1'b0;
    rxEnable = 1'b1;
    rd(8'h48); check(rdVal, 32'h0000_0456);
    rxEnable = 1'b0;
    {txDmaCount, txSmCount} = {16'h0010, 16'h0020};
    rd(8'h48); check(rdVal, 32'h0000_0486);
    rd(8'h4C); check(rdVal, 32'h0000_0579);
    $display("test registers done");
    wr(8'h40, 32'h0000_000A);
    levelInterruptEnable = 1'b1;
    rxDmaCount = 16'h0006;
    pipelineCount = 16'h0004;
    tick(5); check(levelStatus, 1'b0);
    pipelineCount = 16'h0005;
    tick(5); check({levelStatus, levelInterrupt}, 2'b11);
    levelInterruptEnable = 1'b0;
    tick(4); check({levelStatus, levelInterrupt}, 2'b10);
    rd(8'h40); check(rdVal, 32'h0000_000A);
    pipelineCount = 16'h0000;
    $display("test level done");
    wr(8'h38, 32'h0000_0002);
    rd(8'h38); check(rdVal, 32'h0000_0002);
    rxEnable = 1'b1;
    tick(2);
    hsStart = 1'b1;
    tick(1);
    hsStart = 1'b0;
    hsWord(32'h1357_9BDF);
    hsWord(32'hF00D_4321);
    tick(3); check(wordCnt, 2);
    check(lastWord, 32'hF00D_4321);
    check({pcCnt[0], capturing}, 2'b10);
    rxEnable = 1'b0;
    $display("test packet done");
    isDownlink = 1'b1;
    syncByteSelect = 4'b0001;
    wr(8'h38, 32'h0000_003C);
    rxEnable = 1'b1;
    tick(640);
    base = wordCnt;
    u_line.sendWord(32'h0000_003C, 8);
    u_line.sendWord(32'hC0DE_1234, 32);
    waitCnt(foundCnt, 2);
    check(syncReacquireRequest, 1'b0);
    waitCnt(wordCnt, base + 1);
    check(lastWord, 32'hC0DE_1234);
    waitCnt(wordCnt, base + 2);
    check(capturing, 1'b1);
    syncByteSelect = 4'b0101;
    wr(8'h38, 32'h00A6_003C);
    syncReacquireSet = 1'b1;
    tick(1);
    syncReacquireSet = 1'b0;
    tick(1); check(syncReacquireRequest, 1'b1);
    u_line.sendWord(32'h77A6_993C, 32);
    u_line.sendWord(32'h8421_7BDE, 32);
    waitCnt(foundCnt, 3);
    base = wordCnt;
    tick(1); check(syncReacquireRequest, 1'b0);
    waitCnt(wordCnt, base + 1);
    check(lastWord, 32'h8421_7BDE);
    $display("test downlink done");
    // static line idles low, so the first edge of a 0 bit is mid-bit
    rxEnable = 1'b0;
    staticOrFreewheelSelect = 1'b1;
    syncByteSelect = 4'b0001;
    wr(8'h38, 32'h0000_003C);
    tick(128);
    rxEnable = 1'b1;
    tick(8);
    u_line.sendWord(32'h0000_003C, 8);
    u_line.sendWord(32'h2468_ACE1, 32);
    waitCnt(foundCnt, 4);
    base = wordCnt;
    waitCnt(wordCnt, base + 1);
    check(lastWord, 32'h2468_ACE1);
    $display("test static done");
    conclude();
  end
endmodule // test_rx_sync_packet_fifo_level
`default_nettype wire
